/* nbp_port.sv */
// Nonvolatile byte access port: command, pointers and data registers.
// The array itself sits in nbp_mem; this file holds the sequencer that
// runs save, restore and erase, and the byte read and program path.
// Assumes a simple same-clock register port (addr, wr, rd strobes) and a
// working register file reached through a write port and a read bus.
// Assumes the working register file answers wreg_i combinationally for
// the index on wreg_idx_o, so a saved byte lags its index by one cycle.
// Assumes software polls busy_o; requests made while it is high are lost.
//
// Contract
// - Command 0x00 saves working registers to page 0
// - Command 0x01 loads factory block into registers
// - Command 0x02 erases a main memory page
// - Pointer bits 6:3 select one of sixteen pages
// - Pointer bits 2:0 select one of eight rows
// - Byte pointer bits 5:0 select byte in row
// - Data register reads or programs addressed byte
`timescale 1ns/1ps
`default_nettype none
module nbp_port
    import nbp_pkg::*;
#(
    parameter int WREGS = NBP_WREGS // Working registers saved or restored
) (
    input  wire logic       mclk_i,    // Device clock, 100 MHz
    input  wire logic       rst_n_i,   // Asynchronous reset, active low
    input  wire logic [7:0] addr_i,    // Register address
    input  wire logic       wr_i,      // Write strobe, one cycle
    input  wire logic       rd_i,      // Read strobe, one cycle
    input  wire logic [7:0] wdata_i,   // Write data
    output logic      [7:0] rdata_o,   // Read data, held until next read
    output logic            busy_o,    // Operation in progress
    input  wire logic [7:0] wreg_i,    // Working register value at wreg_idx
    output logic      [3:0] wreg_idx_o,// Working register index
    output logic            wreg_we_o, // Working register write pulse
    output logic      [7:0] wreg_o     // Working register write data
);
    // Factory block contents; values here are plain defaults
    // Restore writes this one value to every working register
    localparam logic [7:0] FAC_VAL = 8'h00;

    // All state lives in one struct, filled by one comb block
    nbp_regs_t  r_reg;  // Registered state
    nbp_regs_t  r_next; // Next state
    logic [7:0] m_rd;   // Array read byte
    logic [NBP_ADDR_W-1:0] ptr_addr; // Address from both pointers

    // Elaboration checks: index and counter serve at most 16 registers,
    // and the erase count must match the page geometry
    if (WREGS < 1 || WREGS > 16) begin : g_wregs_bad
        $error("nbp_port: WREGS must be 1..16");
    end
    if (NBP_PAGE_BYTES != NBP_ROWS * NBP_ROW_BYTES) begin : g_geom_bad
        $error("nbp_port: page size and row geometry disagree");
    end

    // Page, row and byte form the array address
    // Bit 7 of the page/row pointer and bits 7:6 of the byte pointer are
    // kept and read back but never reach the array address
    assign ptr_addr = {r_reg.prow[NBP_PAGE_MSB:NBP_PAGE_LSB],
                       r_reg.prow[NBP_ROW_MSB:NBP_ROW_LSB],
                       r_reg.byte_ptr[NBP_BYTE_MSB:0]};

    // Array instance
    // One request per cycle; read data return a cycle later
    nbp_mem #(.AW(NBP_ADDR_W)) u_mem (
        .mclk_i  (mclk_i),
        .req_i   (r_reg.mval),
        .we_i    (r_reg.mreq.we),
        .addr_i  (r_reg.mreq.addr),
        .wdata_i (r_reg.mreq.wdata),
        .rdata_o (m_rd)
    );

    // Next state logic
    always_comb begin
        r_next       = r_reg;
        r_next.mval  = 1'b0;
        r_next.wr_we = 1'b0;
        case (r_reg.st)
            NBP_ST_IDLE: begin
                // Requests are taken only here; busy states drop them
                // Register writes, ignored while busy
                if (wr_i) begin
                    case (addr_i)
                        NBP_OFS_CMD: begin
                            // Keep the code and start the matching job
                            r_next.cmd = wdata_i;
                            r_next.cnt = '0;
                            r_next.fac_idx = '0;
                            if (wdata_i == NBP_CMD_SAVE) begin
                                r_next.st   = NBP_ST_SAVE;
                                r_next.busy = 1'b1;
                            end else if (wdata_i == NBP_CMD_RESTORE) begin
                                r_next.st   = NBP_ST_RESTORE;
                                r_next.busy = 1'b1;
                            end else if (wdata_i == NBP_CMD_ERASE) begin
                                r_next.st   = NBP_ST_ERASE;
                                r_next.busy = 1'b1;
                            end else begin
                                // Other codes are kept and start nothing
                                r_next.st   = NBP_ST_IDLE;
                            end
                        end
                        NBP_OFS_PROW: r_next.prow     = wdata_i;
                        NBP_OFS_BYTE: r_next.byte_ptr = wdata_i;
                        NBP_OFS_DATA: begin
                            // Program the pointed byte
                            // Array write lands one cycle after this
                            r_next.mval       = 1'b1;
                            r_next.mreq.we    = 1'b1;
                            r_next.mreq.addr  = ptr_addr;
                            r_next.mreq.wdata = wdata_i;
                        end
                        default: ;
                    endcase
                end else if (rd_i) begin
                    // Write has priority over read in one cycle
                    case (addr_i)
                        NBP_OFS_CMD:  r_next.rdata = r_reg.cmd;
                        NBP_OFS_PROW: r_next.rdata = r_reg.prow;
                        NBP_OFS_BYTE: r_next.rdata = r_reg.byte_ptr;
                        NBP_OFS_DATA: begin
                            // Fetch the pointed byte
                            r_next.mval      = 1'b1;
                            r_next.mreq.we   = 1'b0;
                            r_next.mreq.addr = ptr_addr;
                            r_next.st        = NBP_ST_RDWAIT;
                            r_next.busy      = 1'b1;
                        end
                        default: r_next.rdata = 8'h00;
                    endcase
                end
            end
            NBP_ST_RDWAIT: begin
                // Array byte is valid after the request cycle
                // The array read is registered, so wait out one cycle
                if (!r_reg.mval) begin
                    r_next.rdata = m_rd;
                    r_next.st    = NBP_ST_IDLE;
                    r_next.busy  = 1'b0;
                end
            end
            NBP_ST_SAVE: begin
                // Copy working registers into page 0, one per cycle.
                // Step 0 only presents index 0; step k writes byte k-1
                // with the value the file returns for index k-1.
                r_next.wr_idx     = r_reg.cnt[3:0];
                r_next.mval       = (r_reg.cnt != '0);
                r_next.mreq.we    = 1'b1;
                r_next.mreq.addr  = {NBP_SAVE_PAGE,
                                     NBP_PAGE_AW'(r_reg.cnt - 10'd1)};
                r_next.mreq.wdata = wreg_i;
                // Step WREGS writes the last register and ends the job
                if (r_reg.cnt == 10'(WREGS)) begin
                    r_next.st   = NBP_ST_IDLE;
                    r_next.busy = 1'b0;
                end
                r_next.cnt = r_reg.cnt + 10'd1;
            end
            NBP_ST_RESTORE: begin
                // Factory values into working registers
                // One register per cycle, index from the factory counter
                r_next.wr_we   = 1'b1;
                r_next.wr_idx  = r_reg.fac_idx;
                r_next.wr_data = FAC_VAL;
                r_next.fac_idx = r_reg.fac_idx + 4'd1;
                if (r_reg.fac_idx == 4'(WREGS - 1)) begin
                    r_next.st = NBP_ST_RSTWAIT;
                end
            end
            NBP_ST_RSTWAIT: begin
                // Let the last register write drain
                // Keeps busy high until the file has taken the last value
                r_next.st   = NBP_ST_IDLE;
                r_next.busy = 1'b0;
            end
            NBP_ST_ERASE: begin
                // Clear every byte of the selected page
                // All ones is the blank level; pointer writes are refused
                // meanwhile, so the page cannot move under the count
                r_next.mval       = 1'b1;
                r_next.mreq.we    = 1'b1;
                r_next.mreq.addr  = {r_reg.prow[NBP_PAGE_MSB:NBP_PAGE_LSB],
                                     r_reg.cnt[NBP_PAGE_AW-1:0]};
                r_next.mreq.wdata = 8'hFF;
                if (r_reg.cnt == 10'(NBP_PAGE_BYTES - 1)) begin
                    r_next.st   = NBP_ST_IDLE;
                    r_next.busy = 1'b0;
                end
                r_next.cnt = r_reg.cnt + 10'd1;
            end
            default: begin
                // Unused state codes fall back to idle
                r_next.st   = NBP_ST_IDLE;
                r_next.busy = 1'b0;
            end
        endcase
    end

    // State register; asynchronous reset loads constants only.
    // The array is not reset: its contents survive like a real
    // nonvolatile store, and software must not read unwritten bytes.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r_reg          <= '0;
            r_reg.st       <= NBP_ST_IDLE;
            r_reg.cmd      <= NBP_RST_CMD;
            r_reg.prow     <= NBP_RST_PROW;
            r_reg.byte_ptr <= NBP_RST_BYTE;
        end else begin
            r_reg <= r_next;
        end
    end

    // Outputs straight from flip-flops
    // No output passes through logic, so every port is glitch free
    assign rdata_o    = r_reg.rdata;
    assign busy_o     = r_reg.busy;
    assign wreg_idx_o = r_reg.wr_idx;
    assign wreg_we_o  = r_reg.wr_we;
    assign wreg_o     = r_reg.wr_data;
endmodule : nbp_port
`default_nettype wire

/* nbp_pkg.sv */
// Package for the nonvolatile byte access port.
// Holds register offsets, field positions, command codes and geometry.
// Assumes an 8-bit register port with an 8-bit register address.
package nbp_pkg;

    // Register offsets on the 8-bit register port
    localparam logic [7:0] NBP_OFS_CMD  = 8'h7B; // Operation command
    localparam logic [7:0] NBP_OFS_PROW = 8'h7C; // Page and row pointer
    localparam logic [7:0] NBP_OFS_BYTE = 8'h7D; // Byte pointer
    localparam logic [7:0] NBP_OFS_DATA = 8'h7E; // Data access

    // Reset values of the software registers
    localparam logic [7:0] NBP_RST_CMD  = 8'h00;
    localparam logic [7:0] NBP_RST_PROW = 8'h00;
    localparam logic [7:0] NBP_RST_BYTE = 8'h00;

    // Command codes
    localparam logic [7:0] NBP_CMD_SAVE    = 8'h00; // Working regs to page 0
    localparam logic [7:0] NBP_CMD_RESTORE = 8'h01; // Factory block to regs
    localparam logic [7:0] NBP_CMD_ERASE   = 8'h02; // Erase selected page

    // Field positions
    localparam int NBP_PAGE_MSB = 6;
    localparam int NBP_PAGE_LSB = 3;
    localparam int NBP_ROW_MSB  = 2;
    localparam int NBP_ROW_LSB  = 0;
    localparam int NBP_BYTE_MSB = 5;

    // Geometry
    localparam int NBP_PAGES      = 16;
    localparam int NBP_ROWS       = 8;
    localparam int NBP_ROW_BYTES  = 64;
    localparam int NBP_PAGE_BYTES = 512;       // Rows times row bytes
    localparam int NBP_ADDR_W     = 13;        // Byte address width
    localparam int NBP_PAGE_AW    = 9;         // Byte within a page
    localparam int NBP_WREGS      = 16;        // Working registers copied
    localparam logic [3:0] NBP_SAVE_PAGE = 4'h0; // User settings page

    // Controller states
    typedef enum logic [2:0] {
        NBP_ST_IDLE    = 3'b000,
        NBP_ST_RDWAIT  = 3'b001,
        NBP_ST_SAVE    = 3'b010,
        NBP_ST_RESTORE = 3'b011,
        NBP_ST_RSTWAIT = 3'b100,
        NBP_ST_ERASE   = 3'b101
    } nbp_state_t;

    // Memory request carrier
    typedef struct packed {
        logic                  we;
        logic [NBP_ADDR_W-1:0] addr;
        logic [7:0]            wdata;
    } nbp_mreq_t;

    // Whole state of the port
    typedef struct packed {
        nbp_state_t           st;
        logic [7:0]           cmd;
        logic [7:0]           prow;
        logic [7:0]           byte_ptr;
        logic [7:0]           rdata;
        logic [NBP_PAGE_AW:0] cnt;
        logic                 busy;
        nbp_mreq_t            mreq;
        logic                 mval;
        logic                 wr_we;
        logic [3:0]           wr_idx;
        logic [7:0]           wr_data;
        logic [3:0]           fac_idx;
    } nbp_regs_t;

endpackage : nbp_pkg

/* nbp_mem.sv */
// Byte-wide nonvolatile array model for the access port.
// Assumes one request per cycle; read data appear one cycle after request.
`timescale 1ns/1ps
`default_nettype none
module nbp_mem
    import nbp_pkg::*;
#(
    parameter int AW = NBP_ADDR_W // Byte address width
) (
    input  wire logic          mclk_i,  // Device clock
    input  wire logic          req_i,   // Access request
    input  wire logic          we_i,    // Write when high
    input  wire logic [AW-1:0] addr_i,  // Byte address
    input  wire logic [7:0]    wdata_i, // Write byte
    output logic      [7:0]    rdata_o  // Registered read byte
);
    // Storage cells
    logic [7:0] mem_reg [0:(1<<AW)-1];

    // Elaboration check on the address width
    if (AW < 1) begin : g_aw_bad
        $error("nbp_mem: address width must be positive");
    end

    // Synchronous write, registered read
    always_ff @(posedge mclk_i) begin
        if (req_i && we_i) begin
            mem_reg[addr_i] <= wdata_i;
        end
        rdata_o <= mem_reg[addr_i];
    end
endmodule : nbp_mem
`default_nettype wire

/* nbp_port_sva.sv */
// Checker for the nonvolatile byte access port, top ports only.
// Assumes nbp_pkg is compiled first; bound to every nbp_port.
`timescale 1ns/1ps
`default_nettype none
module nbp_port_sva
    import nbp_pkg::*;
#(
    parameter int WREGS = NBP_WREGS // Registers saved or restored
) (
    input wire logic       mclk_i,     // Device clock
    input wire logic       rst_n_i,    // Async reset, active low
    input wire logic [7:0] addr_i,     // Register address
    input wire logic       wr_i,       // Write strobe
    input wire logic       rd_i,       // Read strobe
    input wire logic [7:0] wdata_i,    // Write data
    input wire logic [7:0] rdata_o,    // Read data
    input wire logic       busy_o,     // Operation running
    input wire logic [7:0] wreg_i,     // Working register value
    input wire logic [3:0] wreg_idx_o, // Working register index
    input wire logic       wreg_we_o,  // Working register write
    input wire logic [7:0] wreg_o      // Working register data
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    // Command write that the port accepts
    wire logic cmd_go = wr_i && !busy_o && addr_i == NBP_OFS_CMD;
    // Data register read that the port accepts
    wire logic dat_rd = rd_i && !wr_i && !busy_o && addr_i == NBP_OFS_DATA;

    save_busy_a: assert property (
        cmd_go && wdata_i == NBP_CMD_SAVE |->
        ##1 busy_o[*8] ##1 busy_o[*8] ##1 busy_o ##1 !busy_o)
        else $error("save length");
    save_index_a: assert property (
        cmd_go && wdata_i == NBP_CMD_SAVE |->
        ##2 wreg_idx_o == 4'h0 ##15 wreg_idx_o == 4'hF)
        else $error("save index");
    restore_busy_a: assert property (
        cmd_go && wdata_i == NBP_CMD_RESTORE |->
        ##1 busy_o[*8] ##1 busy_o[*8] ##1 busy_o ##1 !busy_o)
        else $error("restore length");
    restore_pulses_a: assert property (
        cmd_go && wdata_i == NBP_CMD_RESTORE |->
        ##2 (wreg_we_o && wreg_idx_o == 4'h0) ##1 wreg_we_o[*7]
        ##1 wreg_we_o[*8] ##1 !wreg_we_o)
        else $error("restore pulses");
    factory_zero_a: assert property (wreg_we_o
        |-> busy_o && wreg_o == 8'h00) else $error("factory data");
    erase_busy_a: assert property (
        cmd_go && wdata_i == NBP_CMD_ERASE |->
        ##1 busy_o ##[511:511] busy_o ##1 !busy_o)
        else $error("erase length");
    data_read_a: assert property (dat_rd
        |-> ##1 busy_o ##1 busy_o ##1 !busy_o) else $error("data read timing");
    busy_cause_a: assert property ($rose(busy_o)
        |-> $past(wr_i || rd_i)) else $error("busy without request");
endmodule : nbp_port_sva
bind nbp_port nbp_port_sva #(.WREGS(WREGS)) nbp_port_sva_i (.mclk_i, .rst_n_i,
    .addr_i, .wr_i, .rd_i, .wdata_i, .rdata_o, .busy_o, .wreg_i, .wreg_idx_o,
    .wreg_we_o, .wreg_o);
`default_nettype wire

/* nbp_port_tb.sv */
// Self-checking bench for the nonvolatile byte access port.
// Assumes nbp_pkg, nbp_mem, nbp_port and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module nbp_port_tb;
    import nbp_pkg::*;
    logic       mclk = 1'b0;     // Device clock
    logic       rst_n = 1'b0;    // Reset, active low
    logic [7:0] addr = 8'h00;    // Register address
    logic       wr = 1'b0;       // Write strobe
    logic       rd = 1'b0;       // Read strobe
    logic [7:0] wdata = 8'h00;   // Write data
    logic [7:0] rdata, wval;     // Read data, working write data
    logic       busy, wwe;       // Busy, working write pulse
    logic [3:0] widx;            // Working register index
    logic [7:0] wfile [16];      // Working register file
    logic [7:0] mem [int];       // Expected array bytes
    int         corner [4] = '{0, 8191, 2567, 3072}; // Edges, pages 5 and 6
    int         err_total = 0;
    int         total_checks = 0;
    int         seed = 32'ha405_033c;

    nbp_port nbp_port_i (.mclk_i(mclk), .rst_n_i(rst_n), .addr_i(addr),
        .wr_i(wr), .rd_i(rd), .wdata_i(wdata), .rdata_o(rdata),
        .busy_o(busy), .wreg_i(wfile[widx]), .wreg_idx_o(widx),
        .wreg_we_o(wwe), .wreg_o(wval));

    // Clock, 10 ns period
    initial forever #5 mclk = ~mclk;
    // Working register file takes the port's writes
    always @(posedge mclk) if (wwe) wfile[widx] <= wval;

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    // Wait, bounded, until the port is idle
    task automatic settle;
        int n;
        n = 0;
        @(negedge mclk);
        while (busy !== 1'b0 && n < 600) begin
            @(negedge mclk);
            n++;
        end
        if (busy !== 1'b0) begin
            err_total++;
            $display("Error %0t: port stays busy", $time);
        end
    endtask : settle
    // One register access, write or read, then idle wait
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        @(posedge mclk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
        rd <= 1'b0;
        settle();
    endtask : bus
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(rdata, e);
    endtask : rdchk
    // First byte address of the page that a page/row pointer selects
    function automatic int page_base(input logic [7:0] pr);
        return int'(pr[6:3]) * NBP_PAGE_BYTES;
    endfunction : page_base
    // Point both pointers at a 13-bit byte address
    task automatic at(input int p);
        bus(1'b1, NBP_OFS_PROW, {1'b0, p[12:6]});
        bus(1'b1, NBP_OFS_BYTE, {2'b00, p[5:0]});
    endtask : at
    task automatic verify_all;
        foreach (mem[k]) begin
            at(k);
            rdchk(NBP_OFS_DATA, mem[k]);
        end
    endtask : verify_all
    task automatic complete_run;
        $display("Checks %0d, errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run

    // Watchdog, well beyond the expected run
    initial begin
        #600_000;
        err_total++;
        complete_run();
    end

    // Main sequence
    initial begin
        int a;
        logic [7:0] v;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        rdchk(NBP_OFS_CMD, NBP_RST_CMD);
        rdchk(NBP_OFS_PROW, NBP_RST_PROW);
        rdchk(NBP_OFS_BYTE, NBP_RST_BYTE);
        rdchk(8'h10, 8'h00);
        for (int i = 0; i < 6; i++) begin
            v = 8'($random(seed));
            bus(1'b1, NBP_OFS_PROW, v);
            rdchk(NBP_OFS_PROW, v);
            bus(1'b1, NBP_OFS_BYTE, ~v);
            rdchk(NBP_OFS_BYTE, ~v);
        end
        // Random bytes plus corner addresses
        for (int i = 0; i < 16; i++) begin
            a = (i < 4) ? corner[i] : ($random(seed) & 32'h0000_1fff);
            v = 8'($random(seed));
            at(a);
            bus(1'b1, NBP_OFS_DATA, v);
            mem[a] = v;
        end
        verify_all();
        // Erase page 5, row 3 selected, pointer write refused meanwhile
        bus(1'b1, NBP_OFS_PROW, 8'h2b);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= NBP_OFS_CMD;
        wdata <= NBP_CMD_ERASE;
        @(posedge mclk);
        addr <= NBP_OFS_PROW;
        wdata <= 8'h00;
        @(posedge mclk);
        wr <= 1'b0;
        settle();
        rdchk(NBP_OFS_PROW, 8'h2b);
        for (int i = 0; i < NBP_PAGE_BYTES; i++) begin
            mem[page_base(8'h2b) + i] = 8'hff;
        end
        verify_all();
        // Save working registers to the user page
        for (int i = 0; i < 16; i++) wfile[i] = 8'($random(seed));
        bus(1'b1, NBP_OFS_CMD, NBP_CMD_SAVE);
        for (int i = 0; i < 16; i++) mem[i] = wfile[i];
        verify_all();
        // Restore factory values over random contents
        for (int i = 0; i < 16; i++) wfile[i] = 8'($random(seed)) | 8'h01;
        bus(1'b1, NBP_OFS_CMD, NBP_CMD_RESTORE);
        for (int i = 0; i < 16; i++) chk(wfile[i], 8'h00);
        // Unknown code is stored and starts nothing
        bus(1'b1, NBP_OFS_CMD, 8'h05);
        rdchk(NBP_OFS_CMD, 8'h05);
        complete_run();
    end
endmodule : nbp_port_tb
`default_nettype wire
